// ### hw/ifkfe_top.v
// layer-3/layer-4 classification key field extractor with apb registers
//
// Behaviour
// - ip flag on ipv4/ipv6 ethertype and version
// - length frames: flag only for aa-aa-03
// - ipv4 flag on 0x800 and version 4
// - fragmented on more-fragments or nonzero offset
// - non-first fragment on nonzero offset only
// - options flag when header length exceeds five
// - frame dscp, or classified when selected
// - destination word from ipv4 or ipv6 low
// - llc: control byte then payload 0..2
// - snap: pid bytes 2..0 then payload 0
// - ip: ipv4 source or ipv6 source low
// - other ethertype: payload bytes 0..3
// - destination select swaps in destination address
// - protocol field from ipv4 or ipv6
// - tcp_or_udp_flag flag on protocol 6 or 17
// - tcp_or_udp_flag flag forced on oam frames
// - ethertype encoded when type at least 0x600
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/1ps
`include "ifkfe_defines.vh"

module ifkfe_top #(
  parameter ADDR_W = 8,
  parameter CNT_W = 16
) (
  input wire clock,
  input wire reset,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // parsed header from the ingress parser
  input wire hdr_valid,
  input wire [15:0] type_len,
  input wire [3:0] ip_version,
  input wire [7:0] llc_dsap,
  input wire [7:0] llc_ssap,
  input wire [7:0] llc_ctrl,
  input wire [23:0] snap_pid_low,
  input wire [31:0] payload_head,
  input wire ipv4_more_frag,
  input wire [12:0] ipv4_frag_offset,
  input wire [3:0] ipv4_hdr_len,
  input wire [7:0] ipv4_protocol,
  input wire [7:0] ipv6_next_header,
  input wire [5:0] frame_dscp,
  input wire [5:0] classified_dscp,
  input wire [31:0] ipv4_src,
  input wire [31:0] ipv4_dst,
  input wire [31:0] ipv6_src_low,
  input wire [31:0] ipv6_dst_low,
  input wire oam_y1731,
  // key towards the match engine
  output wire key_valid,
  output wire ethertype_encoded_flag,
  output wire ip_or_snap_flag,
  output wire ipv4_flag,
  output wire fragmented_flag,
  output wire non_first_fragment_flag,
  output wire header_options_flag,
  output wire [5:0] dscp_key_field,
  output wire [31:0] dest_ip_word,
  output wire [31:0] source_ip_word,
  output wire [7:0] ip_protocol_field,
  output wire tcp_or_udp_flag
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  reg [31:0] prdata_r;
  reg [31:0] prdata_nxt;
  reg pready_r;
  reg pslverr_r;
  reg pslverr_nxt;
  reg [1:0] adv_cfg_r;
  reg key_valid_r;
  reg etype_r;
  reg ip_or_snap_r;
  reg ipv4_r;
  reg frag_r;
  reg non_first_r;
  reg options_r;
  reg [5:0] dscp_r;
  reg [31:0] dip_r;
  reg [31:0] sip_r;
  reg [7:0] proto_r;
  reg tcp_or_udp_flag_r;
  reg [CNT_W-1:0] frames_r;

  wire setup_phase;
  wire access_done;
  wire wr_en;
  wire clr_counters;
  wire dst_select;
  wire cl_dscp_select;
  wire dec_etype;
  wire dec_ipv4;
  wire dec_ipv6;
  wire dec_ip_or_snap;
  wire dec_frag;
  wire dec_non_first;
  wire dec_options;
  wire [7:0] dec_proto;
  wire dec_tcp_or_udp_flag;
  wire [31:0] sel_dip;
  wire [31:0] sel_sip;
  wire [5:0] sel_dscp;
  wire [`IFKFE_NUM_CNT-1:0] cnt_hit;
  wire [CNT_W*`IFKFE_NUM_CNT-1:0] cnt_flat;
  wire [6:0] last_flags;

  // ---------------------------------------------------------------
  // apb handshake
  // ---------------------------------------------------------------
  // one wait-free access: pready rises in the access phase so the
  // read data can come from a flop loaded in the setup cycle
  assign setup_phase = psel && !penable;
  assign access_done = psel && penable && pready_r;
  assign wr_en = access_done && pwrite;
  assign clr_counters = wr_en &&
                        (paddr == `IFKFE_OFS_CLEAR) &&
                        pwdata[`IFKFE_CLR_COUNTERS];

  assign dst_select = adv_cfg_r[`IFKFE_CFG_DST_SEL];
  assign cl_dscp_select = adv_cfg_r[`IFKFE_CFG_CL_DSCP];

  assign last_flags = {tcp_or_udp_flag_r, options_r, non_first_r, frag_r,
                       ipv4_r, ip_or_snap_r, etype_r};

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      pready_r <= 1'b0;
      prdata_r <= 32'h00000000;
      pslverr_r <= 1'b0;
    end else if (setup_phase) begin
      pready_r <= 1'b1;
      prdata_r <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
    end else if (access_done) begin
      pready_r <= 1'b0;
      prdata_r <= 32'h00000000;
      pslverr_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // register read decode
  // ---------------------------------------------------------------
  always @* begin
    prdata_nxt = 32'h00000000;
    pslverr_nxt = 1'b0;
    case (paddr)
      `IFKFE_OFS_CONFIG: begin
        prdata_nxt[1:0] = adv_cfg_r;
      end
      `IFKFE_OFS_STATUS: begin
        prdata_nxt[`IFKFE_ST_FLAGS_LSB +: 7] = last_flags;
        prdata_nxt[`IFKFE_ST_DSCP_LSB +: 6] = dscp_r;
        prdata_nxt[`IFKFE_ST_PROTO_LSB +: 8] = proto_r;
      end
      `IFKFE_OFS_FRAMES: begin
        prdata_nxt[CNT_W-1:0] = frames_r;
      end
      `IFKFE_OFS_CNT_BASE: begin
        prdata_nxt[CNT_W-1:0] = cnt_flat[0 +: CNT_W];
      end
      `IFKFE_OFS_CNT_BASE + 8'h04: begin
        prdata_nxt[CNT_W-1:0] = cnt_flat[CNT_W +: CNT_W];
      end
      `IFKFE_OFS_CNT_BASE + 8'h08: begin
        prdata_nxt[CNT_W-1:0] = cnt_flat[2*CNT_W +: CNT_W];
      end
      `IFKFE_OFS_CNT_BASE + 8'h0c: begin
        prdata_nxt[CNT_W-1:0] = cnt_flat[3*CNT_W +: CNT_W];
      end
      `IFKFE_OFS_LAST_SIP: begin
        prdata_nxt = sip_r;
      end
      `IFKFE_OFS_LAST_DIP: begin
        prdata_nxt = dip_r;
      end
      `IFKFE_OFS_CLEAR: begin
        prdata_nxt = 32'h00000000;
      end
      default: begin
        pslverr_nxt = 1'b1;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // advanced classifier config
  // ---------------------------------------------------------------
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      adv_cfg_r <= `IFKFE_CFG_RESET;
    end else if (wr_en && (paddr == `IFKFE_OFS_CONFIG)) begin
      adv_cfg_r <= pwdata[1:0];
    end
  end

  // ---------------------------------------------------------------
  // field decode
  // ---------------------------------------------------------------
  ifkfe_flag_decode u_flags (
    .type_len(type_len),
    .ip_version(ip_version),
    .llc_dsap(llc_dsap),
    .llc_ssap(llc_ssap),
    .llc_ctrl(llc_ctrl),
    .ipv4_more_frag(ipv4_more_frag),
    .ipv4_frag_offset(ipv4_frag_offset),
    .ipv4_hdr_len(ipv4_hdr_len),
    .ipv4_protocol(ipv4_protocol),
    .ipv6_next_header(ipv6_next_header),
    .oam_y1731(oam_y1731),
    .etype_enc(dec_etype),
    .is_ipv4(dec_ipv4),
    .is_ipv6(dec_ipv6),
    .ip_or_snap(dec_ip_or_snap),
    .fragmented(dec_frag),
    .non_first_frag(dec_non_first),
    .hdr_options(dec_options),
    .ip_proto(dec_proto),
    .tcp_or_udp(dec_tcp_or_udp_flag)
  );

  ifkfe_word_select u_words (
    .etype_enc(dec_etype),
    .is_ipv4(dec_ipv4),
    .is_ipv6(dec_ipv6),
    .ip_or_snap(dec_ip_or_snap),
    .dst_select(dst_select),
    .cl_dscp_select(cl_dscp_select),
    .llc_ctrl(llc_ctrl),
    .snap_pid_low(snap_pid_low),
    .payload_head(payload_head),
    .ipv4_src(ipv4_src),
    .ipv4_dst(ipv4_dst),
    .ipv6_src_low(ipv6_src_low),
    .ipv6_dst_low(ipv6_dst_low),
    .frame_dscp(frame_dscp),
    .classified_dscp(classified_dscp),
    .dest_word(sel_dip),
    .src_word(sel_sip),
    .dscp(sel_dscp)
  );

  // ---------------------------------------------------------------
  // key output stage
  // ---------------------------------------------------------------
  // the key holds between frames so the match engine may sample late;
  // key_valid marks the one cycle in which a new key appears
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      key_valid_r <= 1'b0;
      etype_r <= 1'b0;
      ip_or_snap_r <= 1'b0;
      ipv4_r <= 1'b0;
      frag_r <= 1'b0;
      non_first_r <= 1'b0;
      options_r <= 1'b0;
      dscp_r <= 6'h00;
      dip_r <= 32'h00000000;
      sip_r <= 32'h00000000;
      proto_r <= 8'h00;
      tcp_or_udp_flag_r <= 1'b0;
    end else begin
      key_valid_r <= hdr_valid;
      if (hdr_valid) begin
        etype_r <= dec_etype;
        ip_or_snap_r <= dec_ip_or_snap;
        ipv4_r <= dec_ipv4;
        frag_r <= dec_frag;
        non_first_r <= dec_non_first;
        options_r <= dec_options;
        dscp_r <= sel_dscp;
        dip_r <= sel_dip;
        sip_r <= sel_sip;
        proto_r <= dec_proto;
        tcp_or_udp_flag_r <= dec_tcp_or_udp_flag;
      end
    end
  end

  assign key_valid = key_valid_r;
  assign ethertype_encoded_flag = etype_r;
  assign ip_or_snap_flag = ip_or_snap_r;
  assign ipv4_flag = ipv4_r;
  assign fragmented_flag = frag_r;
  assign non_first_fragment_flag = non_first_r;
  assign header_options_flag = options_r;
  assign dscp_key_field = dscp_r;
  assign dest_ip_word = dip_r;
  assign source_ip_word = sip_r;
  assign ip_protocol_field = proto_r;
  assign tcp_or_udp_flag = tcp_or_udp_flag_r;

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  // ---------------------------------------------------------------
  // frame statistics
  // ---------------------------------------------------------------
  // counters wrap; a frame arriving with a clear still counts,
  // so software never loses an event that races its clear
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      frames_r <= {CNT_W{1'b0}};
    end else if (hdr_valid) begin
      frames_r <= clr_counters ? {{(CNT_W-1){1'b0}}, 1'b1} :
                  frames_r + 1'b1;
    end else if (clr_counters) begin
      frames_r <= {CNT_W{1'b0}};
    end
  end

  assign cnt_hit = {dec_tcp_or_udp_flag, dec_frag, dec_ipv4, dec_ip_or_snap};

  genvar gi;
  generate
    for (gi = 0; gi < `IFKFE_NUM_CNT; gi = gi + 1) begin : g_cnt
      reg [CNT_W-1:0] cnt_r;
      always @(posedge clock or posedge reset) begin
        if (reset) begin
          cnt_r <= {CNT_W{1'b0}};
        end else if (hdr_valid && cnt_hit[gi]) begin
          cnt_r <= clr_counters ? {{(CNT_W-1){1'b0}}, 1'b1} :
                   cnt_r + 1'b1;
        end else if (clr_counters) begin
          cnt_r <= {CNT_W{1'b0}};
        end
      end
      assign cnt_flat[gi*CNT_W +: CNT_W] = cnt_r;
    end
  endgenerate

endmodule // ifkfe_top

// ### hw/ifkfe_defines.vh
// constants of the layer-3/layer-4 key field extractor
`ifndef IFKFE_DEFINES_VH
`define IFKFE_DEFINES_VH

// frame classification constants
`define IFKFE_ETYPE_MIN 16'h0600
`define IFKFE_ETYPE_IPV4 16'h0800
`define IFKFE_ETYPE_IPV6 16'h86dd
`define IFKFE_VER_IPV4 4'h4
`define IFKFE_VER_IPV6 4'h6
`define IFKFE_LLC_SNAP_SAP 8'haa
`define IFKFE_LLC_SNAP_CTRL 8'h03
`define IFKFE_IHL_PLAIN 4'h5
`define IFKFE_PROTO_TCP 8'h06
`define IFKFE_PROTO_UDP 8'h11

// register byte offsets
`define IFKFE_OFS_CONFIG 8'h00
`define IFKFE_OFS_STATUS 8'h04
`define IFKFE_OFS_FRAMES 8'h08
`define IFKFE_OFS_CNT_BASE 8'h0c
`define IFKFE_OFS_LAST_SIP 8'h1c
`define IFKFE_OFS_LAST_DIP 8'h20
`define IFKFE_OFS_CLEAR 8'h24

// config register fields
`define IFKFE_CFG_DST_SEL 0
`define IFKFE_CFG_CL_DSCP 1
`define IFKFE_CFG_RESET 2'h0

// clear register field
`define IFKFE_CLR_COUNTERS 0

// status register fields
`define IFKFE_ST_FLAGS_LSB 0
`define IFKFE_ST_DSCP_LSB 8
`define IFKFE_ST_PROTO_LSB 16

// number of per-flag counters
`define IFKFE_NUM_CNT 4

`endif

// ### hw/ifkfe_flag_decode.v
// frame type flag decoder of the key field extractor
`timescale 1ns/1ps
`include "ifkfe_defines.vh"

module ifkfe_flag_decode (
  input wire [15:0] type_len,
  input wire [3:0] ip_version,
  input wire [7:0] llc_dsap,
  input wire [7:0] llc_ssap,
  input wire [7:0] llc_ctrl,
  input wire ipv4_more_frag,
  input wire [12:0] ipv4_frag_offset,
  input wire [3:0] ipv4_hdr_len,
  input wire [7:0] ipv4_protocol,
  input wire [7:0] ipv6_next_header,
  input wire oam_y1731,
  output wire etype_enc,
  output wire is_ipv4,
  output wire is_ipv6,
  output wire ip_or_snap,
  output wire fragmented,
  output wire non_first_frag,
  output wire hdr_options,
  output wire [7:0] ip_proto,
  output wire tcp_or_udp
);

  wire offset_nz;
  wire is_snap;

  assign etype_enc = (type_len >= `IFKFE_ETYPE_MIN);
  assign is_ipv4 = etype_enc && (type_len == `IFKFE_ETYPE_IPV4) &&
                   (ip_version == `IFKFE_VER_IPV4);
  assign is_ipv6 = etype_enc && (type_len == `IFKFE_ETYPE_IPV6) &&
                   (ip_version == `IFKFE_VER_IPV6);
  assign is_snap = !etype_enc && (llc_dsap == `IFKFE_LLC_SNAP_SAP) &&
                   (llc_ssap == `IFKFE_LLC_SNAP_SAP) &&
                   (llc_ctrl == `IFKFE_LLC_SNAP_CTRL);
  assign ip_or_snap = is_ipv4 || is_ipv6 || is_snap;

  assign offset_nz = (ipv4_frag_offset != 13'h0000);
  assign fragmented = is_ipv4 && (ipv4_more_frag || offset_nz);
  assign non_first_frag = is_ipv4 && offset_nz;
  // header length only, options left unparsed
  assign hdr_options = is_ipv4 && (ipv4_hdr_len > `IFKFE_IHL_PLAIN);

  assign ip_proto = is_ipv4 ? ipv4_protocol :
                    (is_ipv6 ? ipv6_next_header : 8'h00);
  assign tcp_or_udp = ((is_ipv4 || is_ipv6) &&
                       ((ip_proto == `IFKFE_PROTO_TCP) ||
                        (ip_proto == `IFKFE_PROTO_UDP))) || oam_y1731;

endmodule // ifkfe_flag_decode

// ### hw/ifkfe_word_select.v
// address word and dscp selection of the key field extractor
`timescale 1ns/1ps

module ifkfe_word_select (
  input wire etype_enc,
  input wire is_ipv4,
  input wire is_ipv6,
  input wire ip_or_snap,
  input wire dst_select,
  input wire cl_dscp_select,
  input wire [7:0] llc_ctrl,
  input wire [23:0] snap_pid_low,
  input wire [31:0] payload_head,
  input wire [31:0] ipv4_src,
  input wire [31:0] ipv4_dst,
  input wire [31:0] ipv6_src_low,
  input wire [31:0] ipv6_dst_low,
  input wire [5:0] frame_dscp,
  input wire [5:0] classified_dscp,
  output reg [31:0] dest_word,
  output reg [31:0] src_word,
  output reg [5:0] dscp
);

  reg [31:0] ip_src;

  always @* begin
    if (is_ipv4) begin
      dest_word = ipv4_dst;
    end else if (is_ipv6) begin
      dest_word = ipv6_dst_low;
    end else begin
      dest_word = 32'h00000000;
    end
    ip_src = is_ipv4 ? ipv4_src : ipv6_src_low;
    if (etype_enc && ip_or_snap) begin
      src_word = dst_select ? dest_word : ip_src;
    end else if (etype_enc) begin
      src_word = payload_head;
    end else if (ip_or_snap) begin
      src_word = {snap_pid_low, payload_head[31:24]};
    end else begin
      src_word = {llc_ctrl, payload_head[31:8]};
    end
    if (cl_dscp_select) begin
      dscp = classified_dscp;
    end else if (is_ipv4 || is_ipv6) begin
      dscp = frame_dscp;
    end else begin
      dscp = 6'h00;
    end
  end

endmodule // ifkfe_word_select

// ### testbench/ifkfe_parser_model.sv
// ingress parser model presenting one parsed header per send call
`timescale 1ns/1ps
module ifkfe_parser_model #(
  parameter logic [31:0] PL = 32'h11223344,
  parameter logic [23:0] PID = 24'h0a0b0c,
  parameter logic [31:0] V4S = 32'hc0a80001,
  parameter logic [31:0] V4D = 32'hc0a80002,
  parameter logic [31:0] V6S = 32'h0000abcd,
  parameter logic [31:0] V6D = 32'h00001234,
  parameter logic [5:0] FD = 6'h2e,
  parameter logic [5:0] CLD = 6'h0a
) (
  input wire logic clock,
  output logic hdr_valid,
  output logic [15:0] type_len,
  output logic [3:0] ip_version,
  output logic [7:0] llc_dsap,
  output logic [7:0] llc_ssap,
  output logic [7:0] llc_ctrl,
  output logic [23:0] snap_pid_low,
  output logic [31:0] payload_head,
  output logic ipv4_more_frag,
  output logic [12:0] ipv4_frag_offset,
  output logic [3:0] ipv4_hdr_len,
  output logic [7:0] ipv4_protocol,
  output logic [7:0] ipv6_next_header,
  output logic [5:0] frame_dscp,
  output logic [5:0] classified_dscp,
  output logic [31:0] ipv4_src,
  output logic [31:0] ipv4_dst,
  output logic [31:0] ipv6_src_low,
  output logic [31:0] ipv6_dst_low,
  output logic oam_y1731
);
  // ----------------------------------------
  // header presentation
  // ----------------------------------------
  initial begin
    {hdr_valid, type_len, ip_version, llc_dsap, llc_ssap, llc_ctrl} = '0;
    {snap_pid_low, payload_head, ipv4_more_frag, ipv4_frag_offset} = '0;
    {ipv4_hdr_len, ipv4_protocol, ipv6_next_header, frame_dscp} = '0;
    {classified_dscp, ipv4_src, ipv4_dst, ipv6_src_low} = '0;
    {ipv6_dst_low, oam_y1731} = '0;
  end

  task automatic send(logic [15:0] t, logic [3:0] v, logic [7:0] p,
      logic [12:0] ofs, logic mf, logic [3:0] ihl, logic oam, logic sn);
    @(posedge clock);
    hdr_valid <= 1'b1;
    type_len <= t;
    ip_version <= v;
    llc_dsap <= sn ? 8'haa : 8'h42;
    llc_ssap <= sn ? 8'haa : 8'h42;
    // a non-snap control byte shows whether it is really carried
    llc_ctrl <= sn ? 8'h03 : 8'h13;
    snap_pid_low <= PID;
    payload_head <= PL;
    ipv4_more_frag <= mf;
    ipv4_frag_offset <= ofs;
    ipv4_hdr_len <= ihl;
    // the unused protocol source differs so a wrong pick shows
    ipv4_protocol <= t == 16'h0800 ? p : ~p;
    ipv6_next_header <= t == 16'h0800 ? ~p : p;
    frame_dscp <= FD;
    classified_dscp <= CLD;
    ipv4_src <= V4S;
    ipv4_dst <= V4D;
    ipv6_src_low <= V6S;
    ipv6_dst_low <= V6D;
    oam_y1731 <= oam;
    @(posedge clock);
    hdr_valid <= 1'b0;
    // stale once taken: a changed pattern exposes late sampling
    {payload_head, ipv4_src, ipv4_dst} <= ~{PL, V4S, V4D};
    {ipv6_src_low, ipv6_dst_low, oam_y1731} <= ~{V6S, V6D, oam};
  endtask
endmodule // ifkfe_parser_model

// ### testbench/ifkfe_top_assertions.sv
// concurrent checks on the key extractor ports
`timescale 1ns/1ps
module ifkfe_checker (
  input wire clock,
  input wire reset,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire hdr_valid,
  input wire [15:0] type_len,
  input wire [3:0] ip_version,
  input wire ipv4_more_frag,
  input wire [12:0] ipv4_frag_offset,
  input wire [3:0] ipv4_hdr_len,
  input wire oam_y1731,
  input wire key_valid,
  input wire ethertype_encoded_flag,
  input wire ip_or_snap_flag,
  input wire ipv4_flag,
  input wire fragmented_flag,
  input wire non_first_fragment_flag,
  input wire header_options_flag,
  input wire [31:0] dest_ip_word,
  input wire [31:0] source_ip_word,
  input wire [7:0] ip_protocol_field,
  input wire tcp_or_udp_flag
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence
  property p_apb;
    s_setup |=> s_access;
  endproperty
  a_apb: assert property (p_apb) else $error("apb access not answered");
  property p_etype;
    hdr_valid |=> key_valid
      && ethertype_encoded_flag == ($past(type_len) >= 16'h0600);
  endproperty
  a_etype: assert property (p_etype) else $error("etype flag wrong");
  property p_ipv4;
    hdr_valid |=> ipv4_flag
      == ($past(type_len) == 16'h0800 && $past(ip_version) == 4'h4);
  endproperty
  a_ipv4: assert property (p_ipv4) else $error("ipv4 flag wrong");
  property p_frag;
    hdr_valid |=> fragmented_flag == (ipv4_flag
      && ($past(ipv4_more_frag) || $past(ipv4_frag_offset) != 13'h0));
  endproperty
  a_frag: assert property (p_frag) else $error("fragment flag wrong");
  property p_nonfirst;
    hdr_valid |=> non_first_fragment_flag
      == (ipv4_flag && $past(ipv4_frag_offset) != 13'h0);
  endproperty
  a_nonfirst: assert property (p_nonfirst) else $error("nonfirst wrong");
  property p_opts;
    hdr_valid |=> header_options_flag
      == (ipv4_flag && $past(ipv4_hdr_len) > 4'h5);
  endproperty
  a_opts: assert property (p_opts) else $error("options flag wrong");
  property p_tcp;
    hdr_valid |=> tcp_or_udp_flag == ($past(oam_y1731)
      || ip_or_snap_flag && ethertype_encoded_flag
      && (ip_protocol_field == 8'h06 || ip_protocol_field == 8'h11));
  endproperty
  a_tcp: assert property (p_tcp) else $error("tcp_or_udp_flag flag wrong");
  property p_held;
    !hdr_valid |=> !key_valid && $stable(dest_ip_word)
      && $stable(source_ip_word);
  endproperty
  a_held: assert property (p_held) else $error("key moved");
endmodule // ifkfe_checker

bind ifkfe_top ifkfe_checker i_checker (.*);

// ### testbench/ifkfe_top_bench.sv
// self-checking bench of the key field extractor
`timescale 1ns/1ps
module ifkfe_top_bench;
  logic clock, reset, psel, penable, pwrite, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, rd;
  logic [84:0] ex;
  wire [31:0] prdata, dest_ip_word, source_ip_word;
  wire pready, pslverr, key_valid, ethertype_encoded_flag, ip_or_snap_flag;
  wire ipv4_flag, fragmented_flag, non_first_fragment_flag;
  wire header_options_flag, tcp_or_udp_flag, hdr_valid, oam_y1731;
  wire [5:0] dscp_key_field, frame_dscp, classified_dscp;
  wire [7:0] ip_protocol_field, llc_dsap, llc_ssap, llc_ctrl;
  wire [7:0] ipv4_protocol, ipv6_next_header;
  wire [15:0] type_len;
  wire [3:0] ip_version, ipv4_hdr_len;
  wire [23:0] snap_pid_low;
  wire [31:0] payload_head, ipv4_src, ipv4_dst, ipv6_src_low, ipv6_dst_low;
  wire [12:0] ipv4_frag_offset;
  wire ipv4_more_frag;
  int fails = 0, num_checks = 0, cyc = 0, n_ios = 0;
  logic [15:0] t_tl[10] = '{16'h0800, 16'h0800, 16'h0800, 16'h0800,
    16'h86dd, 16'h86dd, 16'h8902, 16'h0600, 16'h05ff, 16'h0040};
  logic [3:0] t_v[10] = '{4, 4, 4, 6, 6, 4, 4, 4, 0, 0};
  logic [7:0] t_p[10] = '{6, 17, 1, 6, 17, 6, 6, 17, 6, 6};
  logic [12:0] t_ofs[10] = '{0, 0, 1, 0, 0, 0, 0, 0, 0, 0};
  logic t_mf[10] = '{0, 1, 0, 0, 0, 0, 0, 0, 0, 0};
  logic [3:0] t_ihl[10] = '{5, 6, 5, 15, 5, 5, 5, 5, 5, 5};
  logic t_oam[10] = '{0, 0, 0, 0, 0, 0, 1, 0, 0, 0};
  logic t_sn[10] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 1};
  logic [1:0] cf[4] = '{2'h0, 2'h1, 2'h2, 2'h3};

  ifkfe_top i_dut (.*);
  ifkfe_parser_model i_pm (.*);

  // ----------------------------------------
  // clock, timeout and reporting
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      complete_run();
    end
  end
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(string n, logic [95:0] e, logic [95:0] s);
    num_checks++;
    if (s !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask

  // ----------------------------------------
  // access tasks and expectations
  // ----------------------------------------
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [84:0] expect_key(int i, logic [1:0] c);
    logic et, v4, v6, ip;
    logic [7:0] pr;
    logic [31:0] dip, sip;
    et = t_tl[i] >= 16'h0600;
    v4 = t_tl[i] == 16'h0800 && t_v[i] == 4'h4;
    v6 = t_tl[i] == 16'h86dd && t_v[i] == 4'h6;
    ip = v4 || v6;
    pr = ip ? t_p[i] : 8'h00;
    dip = v4 ? i_pm.V4D : v6 ? i_pm.V6D : 32'h0;
    sip = v4 ? i_pm.V4S : i_pm.V6S;
    if (ip && c[0]) sip = dip;
    else if (!et) sip = t_sn[i] ? {i_pm.PID, i_pm.PL[31:24]}
      : {8'h13, i_pm.PL[31:8]};
    else if (!ip) sip = i_pm.PL;
    return {t_oam[i] || ip && (pr == 8'h06 || pr == 8'h11),
      v4 && t_ihl[i] > 4'h5, v4 && t_ofs[i] != 13'h0,
      v4 && (t_mf[i] || t_ofs[i] != 13'h0), v4, et ? ip : t_sn[i], et,
      c[1] ? i_pm.CLD : ip ? i_pm.FD : 6'h0, dip, sip, pr};
  endfunction

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {reset, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    apb(1'b0, 8'h00, 32'h0);
    chk("config", 32'h0, rd);
    foreach (cf[c]) begin
      apb(1'b1, 8'h00, {30'h0, cf[c]});
      for (int i = 0; i < 10; i++) begin
        i_pm.send(t_tl[i], t_v[i], t_p[i], t_ofs[i], t_mf[i], t_ihl[i],
          t_oam[i], t_sn[i]);
        #1;
        ex = expect_key(i, cf[c]);
        chk("flags", {ex[84:78], 1'b1}, {
          {tcp_or_udp_flag, header_options_flag, non_first_fragment_flag,
          fragmented_flag, ipv4_flag, ip_or_snap_flag,
          ethertype_encoded_flag}, key_valid});
        chk("words", ex[77:0], {dscp_key_field, dest_ip_word,
          source_ip_word, ip_protocol_field});
        apb(1'b0, 8'h04, 32'h0);
        chk("status", {ex[7:0], 2'h0, ex[77:72], 1'h0, ex[84:78]}, rd);
        apb(1'b0, 8'h1c, 32'h0);
        chk("last source", ex[39:8], rd);
        n_ios += ex[79];
      end
    end
    apb(1'b0, 8'h08, 32'h0);
    chk("frames", 32'd40, rd);
    apb(1'b0, 8'h0c, 32'h0);
    chk("ip count", n_ios, rd);
    apb(1'b0, 8'h28, 32'h0);
    chk("unmapped", 33'h100000000, {er, rd});
    apb(1'b1, 8'h24, 32'h1);
    apb(1'b0, 8'h08, 32'h0);
    chk("cleared", 32'h0, rd);
    reset <= 1'b1;
    @(posedge clock);
    reset <= 1'b0;
    apb(1'b0, 8'h00, 32'h0);
    chk("config after reset", 32'h0, rd);
    complete_run();
  end
endmodule // ifkfe_top_bench
